// >>> verilog/co_cfg.svh
`ifndef CO_CFG_SVH
`define CO_CFG_SVH

// smbus command codes
`define CO_CMD_OPTION 8'h12
`define CO_CMD_CURRENT 8'h14
`define CO_CMD_VOLTAGE 8'h15

// option word power-on value
`define CO_OPTION_RESET 16'hf902

// option word field positions
`define CO_WDOG_HI 14
`define CO_WDOG_LO 13
`define CO_LEARN_BIT 6

// watchdog field codes
`define CO_WDOG_OFF 2'h0
`define CO_WDOG_44 2'h1
`define CO_WDOG_88 2'h2

// timing
`define CO_CLK_HZ 100000000
`define CO_TICK_S 1
`define CO_TIMEOUT_44_S 44
`define CO_TIMEOUT_88_S 88
`define CO_TIMEOUT_175_S 175

`endif

// >>> verilog/co_pkg.sv
`default_nettype none

package co_pkg;

    // option word split into its fields, msb first
    typedef struct packed {
        logic deglitch;
        logic [1:0] wdog;
        logic [1:0] depl;
        logic freq_up;
        logic freq_en;
        logic hs_en;
        logic ls_sel;
        logic learn;
        logic iout_sel;
        logic ac_ind;
        logic boost_en;
        logic boost_ind;
        logic acoc;
        logic inhibit;
    } co_opt_type;

    // analog controls leaving the block
    typedef struct packed {
        logic [1:0] depl_sel;
        logic freq_shift_en;
        logic freq_shift_up;
        logic hs_short_en;
        logic ls_short_sel;
        logic boost_limit_sel;
    } co_analog_type;

    // watchdog condition
    typedef enum logic [0:0] {
        CO_WD_RUN = 1'b0,
        CO_WD_SUSPENDED = 1'b1
    } co_wd_state_type;

endpackage

`default_nettype wire

// >>> verilog/co_option_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "co_cfg.svh"

module co_option_ctrl
    import co_pkg::*;
#(
    parameter int TICK_CYCLES = (`CO_CLK_HZ * `CO_TICK_S)
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // decoded smbus word write
    input wire logic WR_STROBE,
    input wire logic [7:0] WR_CODE,
    input wire logic [15:0] WR_DATA,
    // decoded smbus word read
    input wire logic RD_STROBE,
    input wire logic [7:0] RD_CODE,
    output logic [15:0] RD_DATA,
    output logic RD_VALID,
    // analog status pins
    input wire logic BATT_BELOW_DEPLETION,
    input wire logic BOOST_MODE,
    // power path and charge control
    output logic ADAPTER_PATH_SWITCH,
    output logic BATTERY_PATH_SWITCH,
    output logic CHARGE_SUSPEND,
    output logic BOOST_STOP,
    output co_analog_type ANALOG_CTRL,
    output logic [15:0] OPTION_WORD
);

    localparam logic [26:0] TICK_LAST = 27'(TICK_CYCLES - 1);

    // timeout in seconds for a field value
    function automatic logic [7:0] wd_limit(input logic [1:0] field, input logic boost);
        logic [7:0] lim;
        lim = 8'(`CO_TIMEOUT_175_S);
        if (!boost && field == `CO_WDOG_44) begin
            lim = 8'(`CO_TIMEOUT_44_S);
        end else if (!boost && field == `CO_WDOG_88) begin
            lim = 8'(`CO_TIMEOUT_88_S);
        end
        return lim;
    endfunction

    co_opt_type opt_reg;
    co_opt_type wr_opt;
    logic [2:0] batt_sync_reg;
    logic [2:0] boost_sync_reg;
    logic batt_low_reg;
    logic boost_mode_reg;
    logic cv_nonzero_reg;
    logic [26:0] tick_cnt_reg;
    logic [7:0] sec_cnt_reg;
    co_wd_state_type wd_state_reg;
    logic opt_wr;
    logic vi_wr;
    logic wd_enabled;
    logic boost_active;
    logic depl_hit;
    logic tick;
    logic expire;

    assign wr_opt = co_opt_type'(WR_DATA);
    assign opt_wr = WR_STROBE && WR_CODE == `CO_CMD_OPTION;
    assign vi_wr = WR_STROBE && (WR_CODE == `CO_CMD_VOLTAGE || WR_CODE == `CO_CMD_CURRENT);

    // three-stage synchronisers for the analog comparator levels
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            batt_sync_reg <= 3'h0;
            boost_sync_reg <= 3'h0;
        end else begin
            batt_sync_reg <= {batt_sync_reg[1:0], BATT_BELOW_DEPLETION};
            boost_sync_reg <= {boost_sync_reg[1:0], BOOST_MODE};
        end
    end

    // accept a level once stages two and three agree
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            batt_low_reg <= 1'b0;
            boost_mode_reg <= 1'b0;
        end else begin
            if (batt_sync_reg[1] == batt_sync_reg[2]) begin
                batt_low_reg <= batt_sync_reg[2];
            end
            if (boost_sync_reg[1] == boost_sync_reg[2]) begin
                boost_mode_reg <= boost_sync_reg[2];
            end
        end
    end

    // track whether charge voltage setting is nonzero
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cv_nonzero_reg <= 1'b0;
        end else if (WR_STROBE && WR_CODE == `CO_CMD_VOLTAGE) begin
            cv_nonzero_reg <= (WR_DATA != 16'h0000);
        end
    end

    // depletion detection and boost qualification
    assign depl_hit = batt_low_reg && cv_nonzero_reg;
    assign boost_active = opt_reg.boost_en && boost_mode_reg;
    assign wd_enabled = opt_reg.wdog != `CO_WDOG_OFF;

    // option word storage with self-clearing learn bit
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            opt_reg <= co_opt_type'(`CO_OPTION_RESET);
        end else if (opt_wr) begin
            opt_reg <= wr_opt;
        end else if (opt_reg.learn && depl_hit) begin
            opt_reg.learn <= 1'b0;
        end
    end

    // one-second tick, restarted by every voltage or current write
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tick_cnt_reg <= 27'h0;
        end else if (vi_wr || tick) begin
            tick_cnt_reg <= 27'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 27'h1;
        end
    end

    assign tick = tick_cnt_reg == TICK_LAST;

    // seconds since the last voltage or current write
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sec_cnt_reg <= 8'h00;
        end else if (vi_wr || !wd_enabled) begin
            sec_cnt_reg <= 8'h00;
        end else if (tick && wd_state_reg == CO_WD_RUN) begin
            sec_cnt_reg <= sec_cnt_reg + 8'h01;
        end
    end

    assign expire = wd_enabled && wd_state_reg == CO_WD_RUN
        && sec_cnt_reg >= wd_limit(opt_reg.wdog, boost_active);

    // watchdog suspend state; a write restarts the timer and wins
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            wd_state_reg <= CO_WD_RUN;
        end else begin
            unique case (wd_state_reg)
                CO_WD_RUN: begin
                    if (expire && !vi_wr) begin
                        wd_state_reg <= CO_WD_SUSPENDED;
                    end
                end
                CO_WD_SUSPENDED: begin
                    if (vi_wr || (opt_wr && wr_opt.wdog == `CO_WDOG_OFF)) begin
                        wd_state_reg <= CO_WD_RUN;
                    end
                end
            endcase
        end
    end

    // power path, boost stop and analog controls
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ADAPTER_PATH_SWITCH <= 1'b1;
            BATTERY_PATH_SWITCH <= 1'b0;
            CHARGE_SUSPEND <= 1'b0;
            BOOST_STOP <= 1'b0;
            ANALOG_CTRL <= '0;
            OPTION_WORD <= `CO_OPTION_RESET;
        end else begin
            ADAPTER_PATH_SWITCH <= !opt_reg.learn;
            BATTERY_PATH_SWITCH <= opt_reg.learn;
            CHARGE_SUSPEND <= wd_state_reg == CO_WD_SUSPENDED;
            BOOST_STOP <= boost_active && depl_hit;
            ANALOG_CTRL.depl_sel <= opt_reg.depl;
            ANALOG_CTRL.freq_shift_en <= opt_reg.freq_en;
            ANALOG_CTRL.freq_shift_up <= opt_reg.freq_up;
            ANALOG_CTRL.hs_short_en <= opt_reg.hs_en;
            ANALOG_CTRL.ls_short_sel <= opt_reg.ls_sel;
            ANALOG_CTRL.boost_limit_sel <= boost_active && opt_reg.ls_sel;
            OPTION_WORD <= opt_reg;
        end
    end

    // read answer one cycle after the strobe; other codes return zero
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            RD_DATA <= 16'h0000;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= RD_STROBE;
            if (RD_STROBE) begin
                RD_DATA <= (RD_CODE == `CO_CMD_OPTION) ? 16'(opt_reg) : 16'h0000;
            end
        end
    end

    // checks

    sequence learn_write_s;
        opt_wr && wr_opt.learn;
    endsequence

    sequence learn_end_s;
        opt_reg.learn && depl_hit && !opt_wr;
    endsequence

    learn_start_a: assert property (@(posedge CLK) disable iff (RESET)
        learn_write_s |=> opt_reg.learn ##1 (BATTERY_PATH_SWITCH && !ADAPTER_PATH_SWITCH))
        else $error("learn write did not switch to battery path");

    learn_clear_a: assert property (@(posedge CLK) disable iff (RESET)
        learn_end_s |=> !opt_reg.learn ##1 (ADAPTER_PATH_SWITCH && !BATTERY_PATH_SWITCH))
        else $error("learn bit not cleared at depletion");

    learn_abort_a: assert property (@(posedge CLK) disable iff (RESET)
        (opt_wr && !wr_opt.learn) |=> ##1 ADAPTER_PATH_SWITCH)
        else $error("learn abort did not restore adapter path");

    learn_read_a: assert property (@(posedge CLK) disable iff (RESET)
        (RD_STROBE && RD_CODE == `CO_CMD_OPTION) |=> RD_VALID
        && RD_DATA[`CO_LEARN_BIT] == $past(opt_reg.learn))
        else $error("read learn bit does not match cycle state");

    depl_gate_a: assert property (@(posedge CLK) disable iff (RESET)
        !cv_nonzero_reg |=> !BOOST_STOP)
        else $error("boost stopped with depletion disabled");

    wd_suspend_a: assert property (@(posedge CLK) disable iff (RESET)
        (expire && !vi_wr) |=> ##1 CHARGE_SUSPEND)
        else $error("watchdog expiry did not suspend charging");

    wd_resume_a: assert property (@(posedge CLK) disable iff (RESET)
        (wd_state_reg == CO_WD_SUSPENDED && vi_wr) |=> ##1 !CHARGE_SUSPEND)
        else $error("write did not resume charging");

    wd_boost_a: assert property (@(posedge CLK) disable iff (RESET)
        (boost_active && expire) |-> sec_cnt_reg >= 8'(`CO_TIMEOUT_175_S))
        else $error("boost timeout shorter than 175 s");

    // a field change may expire late, so only the on-time case is pinned
    wd_short_a: assert property (@(posedge CLK) disable iff (RESET)
        (wd_state_reg == CO_WD_RUN && !boost_active && opt_reg.wdog == `CO_WDOG_44
        && sec_cnt_reg == 8'(`CO_TIMEOUT_44_S) && !vi_wr) |=> ##1 CHARGE_SUSPEND)
        else $error("44 s timeout did not suspend charging");

    wd_early_a: assert property (@(posedge CLK) disable iff (RESET)
        $rose(CHARGE_SUSPEND) |-> $past(sec_cnt_reg, 2) >= 8'(`CO_TIMEOUT_44_S))
        else $error("charging suspended before shortest timeout");

    wd_off_a: assert property (@(posedge CLK) disable iff (RESET)
        (wd_state_reg == CO_WD_SUSPENDED && opt_wr && wr_opt.wdog == `CO_WDOG_OFF)
        |=> ##1 !CHARGE_SUSPEND)
        else $error("disabling the watchdog did not resume charging");

    boost_stop_a: assert property (@(posedge CLK) disable iff (RESET)
        (boost_active && depl_hit) |=> BOOST_STOP)
        else $error("boost not stopped at depletion");

    boost_limit_a: assert property (@(posedge CLK) disable iff (RESET)
        ANALOG_CTRL.boost_limit_sel |-> $past(boost_active) && $past(opt_reg.ls_sel))
        else $error("boost limit select without boost");

    depl_map_a: assert property (@(posedge CLK) disable iff (RESET)
        !$past(RESET) |-> ANALOG_CTRL.depl_sel == $past(opt_reg.depl))
        else $error("depletion select does not follow option word");

    freq_map_a: assert property (@(posedge CLK) disable iff (RESET)
        !$past(RESET) |-> ANALOG_CTRL.freq_shift_en == $past(opt_reg.freq_en)
        && ANALOG_CTRL.freq_shift_up == $past(opt_reg.freq_up))
        else $error("frequency shift controls do not follow option word");

    short_map_a: assert property (@(posedge CLK) disable iff (RESET)
        !$past(RESET) |-> ANALOG_CTRL.hs_short_en == $past(opt_reg.hs_en)
        && ANALOG_CTRL.ls_short_sel == $past(opt_reg.ls_sel))
        else $error("short threshold controls do not follow option word");

    rd_other_a: assert property (@(posedge CLK) disable iff (RESET)
        (RD_STROBE && RD_CODE != `CO_CMD_OPTION) |=> RD_VALID && RD_DATA == 16'h0000)
        else $error("read of other code did not return zero");

endmodule

`default_nettype wire

// >>> tb/co_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host controller issuing decoded smbus word writes and reads
module co_host_model (
    // clock
    input wire logic CLK,
    // write side
    output logic WR_STROBE,
    output logic [7:0] WR_CODE,
    output logic [15:0] WR_DATA,
    // read side
    output logic RD_STROBE,
    output logic [7:0] RD_CODE,
    input wire logic [15:0] RD_DATA,
    input wire logic RD_VALID
);
    // idle bus at time zero
    initial begin
        WR_STROBE = 1'b0;
        WR_CODE = 8'h00;
        WR_DATA = 16'h0000;
        RD_STROBE = 1'b0;
        RD_CODE = 8'h00;
    end

    // whole word in one strobe, released lines show inverted data
    task automatic write_word(input logic [7:0] code, input logic [15:0] data);
        @(posedge CLK);
        WR_STROBE <= 1'b1;
        WR_CODE <= code;
        WR_DATA <= data;
        @(posedge CLK);
        WR_STROBE <= 1'b0;
        WR_CODE <= ~code;
        WR_DATA <= ~data;
    endtask

    // request, then take the answer in the cycle after the strobe
    task automatic read_word(input logic [7:0] code, output logic [15:0] data,
                             output logic valid);
        @(posedge CLK);
        RD_STROBE <= 1'b1;
        RD_CODE <= code;
        @(posedge CLK);
        RD_STROBE <= 1'b0;
        RD_CODE <= ~code;
        #1;
        valid = RD_VALID;
        data = RD_DATA;
    endtask
endmodule

`default_nettype wire

// >>> tb/tb_co_option_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_co_option_ctrl;
    import co_pkg::*;
    localparam int TICK = 10;
    logic clk, reset, wr_strobe, rd_strobe, rd_valid, batt_low, boost_mode;
    logic adapter_sw, battery_sw, suspend, boost_stop;
    logic [7:0] wr_code, rd_code;
    logic [15:0] wr_data, rd_data, option_word;
    co_analog_type analog;
    int fails, num_checks;
    logic [15:0] wd_word[3] = '{16'hb902, 16'hd902, 16'hf902};
    int wd_lo[3] = '{44 * TICK - 30, 88 * TICK - 30, 175 * TICK - 30};

    co_option_ctrl #(.TICK_CYCLES(TICK)) co_option_ctrl_i (.CLK(clk), .RESET(reset),
        .WR_STROBE(wr_strobe), .WR_CODE(wr_code), .WR_DATA(wr_data),
        .RD_STROBE(rd_strobe), .RD_CODE(rd_code), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .BATT_BELOW_DEPLETION(batt_low), .BOOST_MODE(boost_mode),
        .ADAPTER_PATH_SWITCH(adapter_sw), .BATTERY_PATH_SWITCH(battery_sw),
        .CHARGE_SUSPEND(suspend), .BOOST_STOP(boost_stop), .ANALOG_CTRL(analog),
        .OPTION_WORD(option_word));
    co_host_model co_host_model_i (.CLK(clk), .WR_STROBE(wr_strobe), .WR_CODE(wr_code),
        .WR_DATA(wr_data), .RD_STROBE(rd_strobe), .RD_CODE(rd_code), .RD_DATA(rd_data),
        .RD_VALID(rd_valid));

    // clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // compare and count
    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // write, then let the outputs settle
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        co_host_model_i.write_word(code, data);
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        co_host_model_i.read_word(code, d, v);
        chk("rd_valid", 16'(v), 16'h0001);
        chk("rd_data", d, exp);
    endtask

    task automatic paths(input logic ad, input logic bat);
        chk("adapter", 16'(adapter_sw), 16'(ad));
        chk("battery", 16'(battery_sw), 16'(bat));
    endtask

    task automatic wait_suspend(input int n, input logic exp);
        repeat (n) @(posedge clk);
        #1;
        chk("suspend", 16'(suspend), 16'(exp));
    endtask

    task automatic set_low(input logic v);
        @(posedge clk);
        batt_low <= v;
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #200000;
        fails = fails + 1;
        conclude();
    end

    // main sequence
    initial begin
        fails = 0;
        num_checks = 0;
        reset = 1'b1;
        batt_low = 1'b0;
        boost_mode = 1'b0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("option", option_word, 16'hf902);
        paths(1'b1, 1'b0);
        chk("depl", 16'(analog.depl_sel), 16'h0003);
        chk("hs", 16'(analog.hs_short_en), 16'h0001);
        chk("shift", 16'({analog.freq_shift_en, analog.ls_short_sel}), 16'h0000);
        rd(8'h12, 16'hf902);
        rd(8'h14, 16'h0000);
        // field decode
        wr(8'h12, 16'h8e82);
        chk("depl", 16'(analog.depl_sel), 16'h0001);
        chk("shift", 16'({analog.freq_shift_en, analog.freq_shift_up}), 16'h0003);
        chk("hs", 16'(analog.hs_short_en), 16'h0000);
        chk("ls", 16'(analog.ls_short_sel), 16'h0001);
        wr(8'h12, 16'h8a82);
        chk("shift", 16'({analog.freq_shift_en, analog.freq_shift_up}), 16'h0002);
        // learn start, abort, depletion finish
        wr(8'h15, 16'h1000);
        wr(8'h12, 16'hf942);
        paths(1'b0, 1'b1);
        rd(8'h12, 16'hf942);
        wr(8'h12, 16'hf902);
        paths(1'b1, 1'b0);
        wr(8'h12, 16'hf942);
        set_low(1'b1);
        paths(1'b1, 1'b0);
        rd(8'h12, 16'hf902);
        set_low(1'b0);
        // zero voltage setting blinds depletion
        wr(8'h15, 16'h0000);
        wr(8'h12, 16'hf942);
        set_low(1'b1);
        paths(1'b0, 1'b1);
        wr(8'h12, 16'hf902);
        set_low(1'b0);
        wr(8'h15, 16'h1000);
        // watchdog timeouts
        for (int i = 0; i < 3; i++) begin
            wr(8'h12, wd_word[i]);
            wr(8'h14, 16'h0100);
            wait_suspend(wd_lo[i], 1'b0);
            wait_suspend(50, 1'b1);
            chk("option", option_word, wd_word[i]);
            wr(8'h15, 16'h1000);
            chk("suspend", 16'(suspend), 16'h0000);
        end
        wr(8'h12, 16'hb902);
        wait_suspend(470, 1'b1);
        wr(8'h12, 16'h9902);
        chk("suspend", 16'(suspend), 16'h0000);
        wait_suspend(1800, 1'b0);
        // boost behaviour
        @(posedge clk);
        boost_mode <= 1'b1;
        wr(8'h12, 16'hb98a);
        wr(8'h14, 16'h0100);
        wait_suspend(500, 1'b0);
        chk("limit", 16'(analog.boost_limit_sel), 16'h0001);
        set_low(1'b1);
        chk("boost_stop", 16'(boost_stop), 16'h0001);
        set_low(1'b0);
        wr(8'h12, 16'hb902);
        wr(8'h14, 16'h0100);
        wait_suspend(470, 1'b1);
        conclude();
    end
endmodule

`default_nettype wire
